/* File: hw/ciold_pkg.sv */
// Package: constants and types for the I/O lock and decode block
package ciold_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [15:0] KEY_ADDR = 16'h8400;
  localparam logic [15:0] MAPBASE_ADDR = 16'h8401;
  localparam logic [15:0] PERIPH_EN_ADDR = 16'h8402;
  localparam logic [15:0] SRAM_PAGE_ADDR = 16'h8403;
  localparam logic [15:0] CTRL_SPACE_LO = 16'h8400;
  localparam logic [15:0] CTRL_SPACE_HI = 16'h845F;
  localparam logic [9:0] LOW_RANGE_MASK = 10'h3FF;
  localparam logic [7:0] UNLOCK_VALUE = 8'h44;
  localparam logic [7:0] KEY_READ_LOCKED = 8'h00;
  localparam logic [7:0] KEY_READ_OPEN = 8'h01;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] SRAM_PAGE_MASK = 8'h7F;
  localparam logic [7:0] PERIPH_EN_MASK = 8'h3F;

  // ****************************************
  // Low range devices
  // ****************************************
  localparam logic [9:0] DMA_LO = 10'h000;
  localparam logic [9:0] DMA_HI = 10'h00F;
  localparam logic [9:0] INTC_LO = 10'h020;
  localparam logic [9:0] INTC_HI = 10'h02F;
  localparam logic [9:0] TIMER_LO = 10'h040;
  localparam logic [9:0] TIMER_HI = 10'h043;
  localparam logic [9:0] PORTS_LO = 10'h060;
  localparam logic [9:0] PORTS_HI = 10'h062;
  localparam logic [9:0] DMAPG_LO = 10'h081;
  localparam logic [9:0] DMAPG_HI = 10'h083;
  localparam logic [9:0] NMI_MASK_ADDR = 10'h0A0;
  localparam logic [9:0] PRN_PRI_LO = 10'h378;
  localparam logic [9:0] PRN_SEC_LO = 10'h278;
  localparam logic [9:0] PRN_MONO_LO = 10'h38C;
  localparam logic [9:0] SER_PRI_LO = 10'h3F8;
  localparam logic [9:0] SER_SEC_LO = 10'h2F8;

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int PRN_FIELD_LSB = 0;
  localparam int SER_FIELD_LSB = 2;
  localparam int VID_FIELD_LSB = 4;
  localparam int NMI_EN_BIT = 7;

  typedef enum logic [1:0] {
    CIOLD_VID_OFF = 2'b00,
    CIOLD_VID_MONO = 2'b01,
    CIOLD_VID_COLOUR = 2'b10,
    CIOLD_VID_ALT = 2'b11
  } ciold_video_t;

  // One-hot chip selects for low range devices
  typedef struct packed {
    logic dma;
    logic intc;
    logic timer;
    logic ports;
    logic dmaPage;
    logic nmiMask;
    logic printer;
    logic serial;
    logic mapPage;
    logic mapData;
  } ciold_sel_t;

  // Control outputs from the register bank
  typedef struct packed {
    logic [7:0] mapperBase;
    logic [1:0] printerMode;
    logic [1:0] serialMode;
    ciold_video_t videoMode;
    logic [6:0] sramPage;
    logic nmiEnable;
    logic unlocked;
  } ciold_ctrl_t;

endpackage : ciold_pkg

/* File: hw/ciold_top.sv */
// Module: I/O address decode and key-locked control register bank
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// What this block does
// R01: Writing unlock value opens control space
// R02: Any other key write locks again
// R03: Key reads zero while locked
// R04: Key reads one while unlocked
// R05: Addresses above ten bits alias low
// R06: Key address fully decoded, never aliased
// R07: Unlocked: low peripherals stop aliasing into control space
// R08: Control registers answer only when unlocked
// R09: Internal hits stay off expansion bus; NMI mask accesses still go out on it
// R10: Mapper base compares address bits 9:2
// R11: Base plus zero, one share page select
// R12: Base plus two, three carry map bytes
// R13: Enable bits 1:0 place printer port
// R14: Enable bits 3:2 place serial controller
// R15: Enable bits 5:4 select video controller
// R16: Enable upper bits read as zero
// R17: SRAM page uses seven low bits
// R18: Low range decodes fixed system devices
// R19: Software avoids partially decoded gaps
// R20: Software picks non-colliding mapper base
// R21: Reset leaves control space locked
// ****************************************
module ciold_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Processor I/O bus
  input wire logic ioStrobe,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  // Register read answer
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  // Decode results
  output ciold_pkg::ciold_sel_t devSel,
  output logic expBusCycle,
  output logic [5:0] pageSelect,
  output logic [7:0] mapAddrLow,
  output logic [7:0] mapAddrHigh,
  // Control state
  output ciold_pkg::ciold_ctrl_t ctrl
);
  import ciold_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic inRange(input logic [9:0] a,
                                   input logic [9:0] lo,
                                   input logic [9:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  logic unlockedQ;
  logic [7:0] mapperBaseQ;
  logic [7:0] periphEnQ;
  logic [7:0] sramPageQ;
  logic nmiEnQ;
  logic [5:0] pageSelQ;
  logic [7:0] mapLowQ;
  logic [7:0] mapHighQ;

  wire logic [9:0] lowAddr = ioAddr[9:0]; // see R05
  wire logic inCtrlSpace = (ioAddr >= CTRL_SPACE_LO) &&
                           (ioAddr <= CTRL_SPACE_HI);
  // Unlocked: control window no longer folds onto low devices
  wire logic lowVisible = ~(unlockedQ && inCtrlSpace); // see R07
  wire logic keyHit = ioStrobe && (ioAddr == KEY_ADDR); // see R06
  wire logic ctrlOpen = ioStrobe && unlockedQ; // see R08
  wire logic baseHit = ctrlOpen && (ioAddr == MAPBASE_ADDR);
  wire logic enHit = ctrlOpen && (ioAddr == PERIPH_EN_ADDR);
  wire logic sramHit = ctrlOpen && (ioAddr == SRAM_PAGE_ADDR);
  wire logic lowCycle = ioStrobe && lowVisible && (ioAddr != KEY_ADDR);

  wire logic [1:0] prnMode = periphEnQ[PRN_FIELD_LSB +: 2];
  wire logic [1:0] serMode = periphEnQ[SER_FIELD_LSB +: 2];
  wire logic selDma = lowCycle && inRange(lowAddr, DMA_LO, DMA_HI);
  wire logic selIntc = lowCycle && inRange(lowAddr, INTC_LO, INTC_HI);
  wire logic selTimer = lowCycle && inRange(lowAddr, TIMER_LO, TIMER_HI);
  wire logic selPorts = lowCycle && inRange(lowAddr, PORTS_LO, PORTS_HI);
  wire logic selDmaPg = lowCycle && inRange(lowAddr, DMAPG_LO, DMAPG_HI);
  wire logic selNmi = lowCycle && (lowAddr == NMI_MASK_ADDR); // see R18
  // Printer window sizes differ: eight ports or four in mono slot
  wire logic prnPri = inRange(lowAddr, PRN_PRI_LO, PRN_PRI_LO + 10'h007);
  wire logic prnSec = inRange(lowAddr, PRN_SEC_LO, PRN_SEC_LO + 10'h007);
  wire logic prnMono = inRange(lowAddr, PRN_MONO_LO,
                               PRN_MONO_LO + 10'h003);
  wire logic selPrn = lowCycle && ((prnMode == 2'b01 && prnPri) ||
                                   (prnMode == 2'b10 && prnSec) ||
                                   (prnMode == 2'b11 && prnMono)); // see R13
  wire logic serPri = inRange(lowAddr, SER_PRI_LO, SER_PRI_LO + 10'h007);
  wire logic serSec = inRange(lowAddr, SER_SEC_LO, SER_SEC_LO + 10'h007);
  wire logic selSer = lowCycle && ((serMode == 2'b01 && serPri) ||
                                   (serMode == 2'b10 && serSec)); // see R14
  // Mapper ports: four ports at base, base word on A9..A2
  wire logic mapHit = lowCycle && (lowAddr[9:2] == mapperBaseQ); // see R10
  wire logic selMapPage = mapHit && !lowAddr[1]; // see R11
  wire logic selMapData = mapHit && lowAddr[1]; // see R12
  wire logic internalHit = selDma | selIntc | selTimer | selPorts |
                           selDmaPg | selPrn | selSer | selMapPage |
                           selMapData | keyHit | (ctrlOpen && inCtrlSpace);
  // NMI mask writes are also mirrored onto the expansion bus
  wire logic expNext = ioStrobe &&
                       (!internalHit || (selNmi && ioWrite)); // see R09
  wire ciold_sel_t selNext = '{dma: selDma, intc: selIntc,
                               timer: selTimer, ports: selPorts,
                               dmaPage: selDmaPg, nmiMask: selNmi,
                               printer: selPrn, serial: selSer,
                               mapPage: selMapPage, mapData: selMapData};

  // ****************************************
  // Read data
  // ****************************************
  wire logic [7:0] keyRead = unlockedQ ? KEY_READ_OPEN
                                       : KEY_READ_LOCKED; // see R03 R04
  wire logic [7:0] mapRead = !lowAddr[0] ? mapLowQ : mapHighQ;
  wire logic [7:0] rdNext =
    keyHit ? keyRead :
    baseHit ? mapperBaseQ :
    enHit ? (periphEnQ & PERIPH_EN_MASK) : // see R16
    sramHit ? (sramPageQ & SRAM_PAGE_MASK) :
    selMapPage ? {2'b00, pageSelQ} :
    selMapData ? mapRead : RESET_BYTE;
  wire logic rdHit = !ioWrite && (keyHit | baseHit | enHit | sramHit |
                                  selMapPage | selMapData);

  // ****************************************
  // Register writes
  // ****************************************
  wire logic wr = ioWrite;
  wire logic unlockedD = (keyHit && wr) ? (ioWrData == UNLOCK_VALUE)
                                        : unlockedQ; // see R01 R02

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unlockedQ <= 1'b0; // see R21
      mapperBaseQ <= RESET_BYTE;
      periphEnQ <= RESET_BYTE;
      sramPageQ <= RESET_BYTE;
      nmiEnQ <= 1'b0;
      pageSelQ <= 6'h00;
      mapLowQ <= RESET_BYTE;
      mapHighQ <= RESET_BYTE;
    end else begin
      unlockedQ <= unlockedD;
      if (baseHit && wr) mapperBaseQ <= ioWrData;
      if (enHit && wr) periphEnQ <= ioWrData & PERIPH_EN_MASK; // see R15
      if (sramHit && wr) sramPageQ <= ioWrData & SRAM_PAGE_MASK; // see R17
      if (selNmi && wr) nmiEnQ <= ioWrData[NMI_EN_BIT];
      if (selMapPage && wr) pageSelQ <= ioWrData[5:0];
      if (selMapData && wr && !lowAddr[0]) mapLowQ <= ioWrData;
      if (selMapData && wr && lowAddr[0]) mapHighQ <= ioWrData;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ioRdData <= RESET_BYTE;
      ioRdValid <= 1'b0;
      devSel <= '0;
      expBusCycle <= 1'b0;
      ctrl <= '0;
    end else begin
      ioRdData <= rdHit ? rdNext : RESET_BYTE;
      ioRdValid <= ioStrobe && rdHit;
      devSel <= selNext;
      expBusCycle <= expNext;
      ctrl <= '{mapperBase: mapperBaseQ,
                printerMode: prnMode,
                serialMode: serMode,
                videoMode: ciold_video_t'(periphEnQ[VID_FIELD_LSB +: 2]),
                sramPage: sramPageQ[6:0],
                nmiEnable: nmiEnQ,
                unlocked: unlockedQ};
    end
  end

  assign pageSelect = pageSelQ;
  assign mapAddrLow = mapLowQ;
  assign mapAddrHigh = mapHighQ;

endmodule : ciold_top
`default_nettype wire

/* File: verif/ciold_io_host.sv */
// Processor I/O bus model issuing byte reads and writes
`timescale 1ns/10ps
`default_nettype none
module ciold_io_host (
  // Clock
  input wire logic clk_sys,
  // Bus to the block
  output logic ioStrobe,
  output logic ioWrite,
  output logic [15:0] ioAddr,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData
);
  initial begin
    ioStrobe = 1'b0;
    ioWrite = 1'b0;
    ioAddr = 16'hFFFF;
    ioWrData = 8'hFF;
  end
  task automatic xfer(input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    ioStrobe = 1'b1;
    ioWrite = w;
    ioAddr = a;
    ioWrData = d;
    @(posedge clk_sys);
    @(negedge clk_sys);
    q = ioRdData;
    ioStrobe = 1'b0;
    // Released lines carry no stale value
    ioAddr = ~a;
    ioWrData = ~d;
  endtask : xfer
endmodule : ciold_io_host
`default_nettype wire

/* File: verif/ciold_top_monitor.sv */
// Checker: bus-level properties of the I/O lock and decode block
`timescale 1ns/10ps
`default_nettype none
module ciold_top_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus and results
  input wire logic ioStrobe,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic ioRdValid,
  input wire ciold_pkg::ciold_sel_t devSel,
  input wire logic expBusCycle,
  input wire logic [5:0] pageSelect,
  input wire ciold_pkg::ciold_ctrl_t ctrl
);
  import ciold_pkg::*;
  wire logic inCtl = ioAddr inside {[CTRL_SPACE_LO:CTRL_SPACE_HI]};
  wire logic wr = ioStrobe && ioWrite;
  wire logic rd = ioStrobe && !ioWrite;
  wire logic kWr = wr && ioAddr == KEY_ADDR;
  wire logic low = ioStrobe && !inCtl;
  wire logic [9:0] a = ioAddr[9:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_KEY_OPEN: assert property (kWr && ioWrData == UNLOCK_VALUE
    |-> ##2 ctrl.unlocked) else $error("unlock ignored");
  AST_KEY_CLOSE: assert property (kWr && ioWrData != UNLOCK_VALUE
    |-> ##2 !ctrl.unlocked) else $error("lock ignored");
  AST_KEY_READ: assert property (rd && ioAddr == KEY_ADDR
    |=> ioRdValid && ioRdData == {7'h00, ctrl.unlocked})
    else $error("bad key readback");
  AST_LOCKED_REFUSE: assert property (rd && ioAddr > KEY_ADDR
    && ioAddr <= SRAM_PAGE_ADDR ##1 !ctrl.unlocked
    |-> !ioRdValid && ioRdData == 8'h00) else $error("locked reg answered");
  AST_ALIAS_TIMER: assert property (low
    && a inside {[TIMER_LO:TIMER_HI]} |=> devSel.timer)
    else $error("timer alias missed");
  AST_OPEN_NO_ALIAS: assert property (ioStrobe && inCtl
    ##1 ctrl.unlocked |-> devSel == '0) else $error("control space aliased");
  AST_NMI_EXPBUS: assert property (wr && !inCtl
    && a == NMI_MASK_ADDR |=> expBusCycle && devSel.nmiMask)
    else $error("mask write not on expansion bus");
  AST_DMA_INTERNAL: assert property (low && a <= DMA_HI
    |=> !expBusCycle && devSel.dma) else $error("internal access leaked");
  AST_PAGE_SELECT: assert property (wr && !inCtl && !a[1]
    && a[9:2] == ctrl.mapperBase |=> pageSelect == $past(ioWrData[5:0]))
    else $error("page select not written");
  AST_EN_UPPER_ZERO: assert property (rd
    && ioAddr == PERIPH_EN_ADDR |=> ioRdData[7:6] == 2'b00)
    else $error("enable upper bits set");
  COV_UNLOCK: cover property (kWr && ioWrData == UNLOCK_VALUE);
  COV_NMI: cover property (wr && !inCtl && a == NMI_MASK_ADDR);
  COV_RELOCK: cover property (kWr && ioWrData != UNLOCK_VALUE);
endmodule : ciold_top_monitor
bind ciold_top ciold_top_monitor mon (.clk_sys, .rst_b, .ioStrobe,
  .ioWrite, .ioAddr, .ioWrData, .ioRdData, .ioRdValid, .devSel,
  .expBusCycle, .pageSelect, .ctrl);
`default_nettype wire

/* File: verif/ciold_bench.sv */
// Testbench: lock, register and decode scenarios
`timescale 1ns/10ps
`default_nettype none
module ciold_bench;
  import ciold_pkg::*;
  logic clk_sys;
  logic rst_b;
  logic ioStrobe;
  logic ioWrite;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData;
  logic [7:0] ioRdData;
  logic ioRdValid;
  ciold_sel_t devSel;
  logic expBusCycle;
  logic [5:0] pageSelect;
  logic [7:0] mapAddrLow;
  logic [7:0] mapAddrHigh;
  ciold_ctrl_t ctrl;
  logic [7:0] q;
  int errors;
  int compares;
  ciold_top dut (.clk_sys, .rst_b, .ioStrobe, .ioWrite, .ioAddr, .ioWrData,
    .ioRdData, .ioRdValid, .devSel, .expBusCycle, .pageSelect, .mapAddrLow,
    .mapAddrHigh, .ctrl);
  ciold_io_host host (.clk_sys, .ioStrobe, .ioWrite, .ioAddr, .ioWrData,
    .ioRdData);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] want);
    host.xfer(1'b0, a, 8'h00, q);
    check(16'(q), 16'(want));
  endtask : rd
  // Sets the enable register, then one access and its chip select
  task automatic row(input logic [7:0] en, input logic [15:0] a,
      input logic w, input logic [9:0] sel);
    wr(PERIPH_EN_ADDR, en);
    @(negedge clk_sys);
    check(16'({ctrl.videoMode, ctrl.serialMode, ctrl.printerMode}),
      16'(en[5:0]));
    host.xfer(w, a, 8'h80, q);
    check(16'(devSel), 16'(sel));
  endtask : row
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    summarize();
  end
  initial begin
    errors = 0;
    compares = 0;
    rst_b = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    rd(KEY_ADDR, KEY_READ_LOCKED);
    wr(PERIPH_EN_ADDR, 8'h3F);
    wr(KEY_ADDR, UNLOCK_VALUE);
    rd(KEY_ADDR, KEY_READ_OPEN);
    check(16'(ioRdValid), 16'h0001);
    rd(PERIPH_EN_ADDR, 8'h00);
    wr(PERIPH_EN_ADDR, 8'hFF);
    rd(PERIPH_EN_ADDR, PERIPH_EN_MASK);
    wr(SRAM_PAGE_ADDR, 8'hFF);
    rd(SRAM_PAGE_ADDR, SRAM_PAGE_MASK);
    // Base 208h keeps the ports clear of other devices
    wr(MAPBASE_ADDR, 8'h82);
    rd(MAPBASE_ADDR, 8'h82);
    row(8'h00, 16'hF040, 1'b0, 10'h080);
    row(8'h10, 16'h000F, 1'b0, 10'h200);
    check(16'(expBusCycle), 16'h0000);
    row(8'h20, 16'h0021, 1'b0, 10'h100);
    row(8'h30, 16'h0062, 1'b0, 10'h040);
    row(8'h00, 16'h0081, 1'b0, 10'h020);
    row(8'h00, 16'h00A0, 1'b1, 10'h010);
    check(16'(expBusCycle), 16'h0001);
    @(negedge clk_sys);
    check(16'(ctrl.nmiEnable), 16'h0001);
    row(8'h01, 16'h037F, 1'b0, 10'h008);
    row(8'h02, 16'h0278, 1'b0, 10'h008);
    row(8'h03, 16'h038C, 1'b0, 10'h008);
    row(8'h03, 16'h0378, 1'b0, 10'h000);
    row(8'h04, 16'h03FF, 1'b0, 10'h004);
    row(8'h08, 16'h02F8, 1'b0, 10'h004);
    row(8'h0C, 16'h03F8, 1'b0, 10'h000);
    row(8'h00, 16'h020B, 1'b0, 10'h001);
    row(8'h00, 16'h8420, 1'b0, 10'h000);
    wr(16'h0208, 8'h07);
    check(16'(pageSelect), 16'h0007);
    wr(16'h0209, 8'h29);
    check(16'(pageSelect), 16'h0029);
    wr(16'h020A, 8'h5A);
    wr(16'h020B, 8'hA5);
    check({mapAddrHigh, mapAddrLow}, 16'hA55A);
    wr(KEY_ADDR, 8'h45);
    rd(KEY_ADDR, KEY_READ_LOCKED);
    check(16'(devSel), 16'h0000);
    rd(SRAM_PAGE_ADDR, 8'h00);
    check(16'(ioRdValid), 16'h0000);
    host.xfer(1'b0, 16'h8420, 8'h00, q);
    check(16'(devSel), 16'h0100);
    summarize();
  end
endmodule : ciold_bench
`default_nettype wire
